// *** rtl/io_status_skip_resume_exec.sv ***
`timescale 1ns/1ns

module io_status_skip_resume_exec
  import io_status_pkg::*;
(
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  // Sequence control
  input  wire logic                    seq_start_i,
  input  wire logic                    decrement_p_i,
  input  wire logic [FUNC_WIDTH-1:0]   instr_func_i,
  input  wire logic [SUBF_WIDTH-1:0]   instr_subf_i,
  input  wire logic [CHAN_SEL_W-1:0]   instr_chan_i,
  // Channel status pins
  input  wire logic [NUM_CHANNELS-1:0] input_buffer_active_i,
  input  wire logic [NUM_CHANNELS-1:0] output_buffer_active_i,
  input  wire logic [NUM_CHANNELS-1:0] function_buffer_active_i,
  input  wire logic [NUM_CHANNELS-1:0] ack_sending_i,
  input  wire logic [NUM_CHANNELS-1:0] word_sent_i,
  input  wire logic [NUM_CHANNELS-1:0] output_request_i,
  input  wire logic                    intercomputer_mode_i,
  // Results
  output logic [P_WIDTH-1:0]           p_o,
  output logic [P_WIDTH-1:0]           memory_address_o,
  output logic                         memory_start_o,
  output logic                         seq_busy_o,
  output logic [NUM_GROUPS-1:0]        output_available_o,
  output logic [NUM_GROUPS-1:0]        resume_o,
  output logic                         resume_fault_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] ia_s1, ia_s2, oa_s1, oa_s2, fa_s1, fa_s2;
  logic [NUM_CHANNELS-1:0] ak_s1, ak_s2, ws_s1, ws_s2, rq_s1, rq_s2;
  logic                    ic_s1, ic_s2;

  always_ff @(posedge sys_clk_i) begin
    ia_s1 <= input_buffer_active_i;
    ia_s2 <= ia_s1;
    oa_s1 <= output_buffer_active_i;
    oa_s2 <= oa_s1;
    fa_s1 <= function_buffer_active_i;
    fa_s2 <= fa_s1;
    ak_s1 <= ack_sending_i;
    ak_s2 <= ak_s1;
    ws_s1 <= word_sent_i;
    ws_s2 <= ws_s1;
    rq_s1 <= output_request_i;
    rq_s2 <= rq_s1;
    ic_s1 <= intercomputer_mode_i;
    ic_s2 <= ic_s1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_GROUPS-1:0] group_or
    (input logic [NUM_CHANNELS-1:0] v);
    logic [NUM_GROUPS-1:0] r;
    r = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      r[g] = |v[g*CHAN_PER_GRP +: CHAN_PER_GRP];
    end
    return r;
  endfunction

  function automatic logic [GROUP_SEL_W-1:0] group_of
    (input logic [CHAN_SEL_W-1:0] ch);
    return ch[CHAN_SEL_W-1 -: GROUP_SEL_W];
  endfunction

  // ----------------------------------------------------------------
  // Sequencer: sixteen slots, T1.1 through T4.4
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, RUN} seq_state_t;
  seq_state_t              state_reg;
  logic [SLOT_W-1:0]       slot_reg;
  logic                    decr_reg;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= IDLE;
      slot_reg  <= SLOT_T1_1;
      decr_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (seq_start_i) begin
            state_reg <= RUN;
            slot_reg  <= SLOT_T1_1;
            decr_reg  <= decrement_p_i;
          end
        end
        RUN: begin
          slot_reg <= slot_reg + 4'h1;
          if (slot_reg == SLOT_T4_4) begin
            state_reg <= IDLE;
          end
        end
      endcase
    end
  end

  logic running;
  assign running    = (state_reg == RUN);
  assign seq_busy_o = running;

  // ----------------------------------------------------------------
  // Instruction latch and translator
  // ----------------------------------------------------------------
  logic [FUNC_WIDTH-1:0] func_reg;
  logic [SUBF_WIDTH-1:0] subf_reg;
  logic [CHAN_SEL_W-1:0] channel_field_reg;
  logic                  function_latched_flag;
  logic                  trans_valid_reg;
  logic [SUBF_WIDTH-1:0] trans_subf_reg;
  logic [CHAN_SEL_W-1:0] trans_chan_reg;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      func_reg              <= '0;
      subf_reg              <= '0;
      channel_field_reg     <= '0;
      function_latched_flag <= 1'b0;
      trans_valid_reg       <= 1'b0;
      trans_subf_reg        <= '0;
      trans_chan_reg        <= '0;
    end else if (running) begin
      if (slot_reg == SLOT_T1_3) begin
        func_reg              <= '0;
        function_latched_flag <= 1'b0;
      end
      if (slot_reg == SLOT_T2_4) begin
        func_reg              <= instr_func_i;
        subf_reg              <= instr_subf_i;
        channel_field_reg     <= instr_chan_i;
        function_latched_flag <= 1'b1;
      end
      if (slot_reg == SLOT_T3_1) begin
        trans_valid_reg <= 1'b0;
        trans_subf_reg  <= '0;
        trans_chan_reg  <= '0;
      end
      if (slot_reg == SLOT_T3_2 && function_latched_flag) begin
        trans_valid_reg <= (func_reg == MAJOR_IO_STATUS);
        trans_subf_reg  <= subf_reg;
        trans_chan_reg  <= channel_field_reg;
      end
    end else begin
      trans_valid_reg <= 1'b0;
    end
  end

  logic is_skip, is_setres;
  assign is_skip   = trans_valid_reg && !decr_reg &&
                     (trans_subf_reg == SUB_SKIP_INPUT  ||
                      trans_subf_reg == SUB_SKIP_OUTPUT ||
                      trans_subf_reg == SUB_SKIP_FUNC   ||
                      trans_subf_reg == SUB_SKIP_NORES);
  assign is_setres = trans_valid_reg && !decr_reg &&
                     (trans_subf_reg == SUB_SET_RESUME);

  // ----------------------------------------------------------------
  // Resume flags and output availability
  // ----------------------------------------------------------------
  logic [NUM_GROUPS-1:0] resume_reg;
  logic [NUM_GROUPS-1:0] ack_grp, sent_grp, req_grp, force_grp;
  logic [NUM_GROUPS-1:0] avail;

  assign ack_grp  = group_or(ak_s2);
  assign sent_grp = group_or(ws_s2);
  assign req_grp  = group_or(rq_s2);
  assign avail    = resume_reg & ~ack_grp;

  always_comb begin
    force_grp = '0;
    if (running && is_setres && slot_reg == SLOT_T4_2) begin
      force_grp[group_of(trans_chan_reg)] = 1'b1;
    end
  end

  // Set wins over the word-sent clear when both land in one cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      resume_reg <= RES_RESET;
    end else if (ic_s2) begin
      resume_reg <= (resume_reg & ~sent_grp) | req_grp | force_grp;
    end else begin
      resume_reg <= resume_reg | ack_grp | force_grp;
    end
  end

  assign resume_o           = resume_reg;
  assign output_available_o = avail;

  // ----------------------------------------------------------------
  // Resume-fault timers, intercomputer mode only
  // ----------------------------------------------------------------
  logic [RES_CNT_W-1:0] res_cnt_reg [NUM_GROUPS];
  logic                 fault_reg;
  logic                 fault_next;

  always_comb begin
    fault_next = 1'b0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (res_cnt_reg[g] == RES_CNT_W'(RESUME_LIMIT_CYCLES)) begin
        fault_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        res_cnt_reg[g] <= '0;
      end
      fault_reg <= 1'b0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (!ic_s2 || resume_reg[g]) begin
          res_cnt_reg[g] <= '0;
        end else if (res_cnt_reg[g] !=
                     RES_CNT_W'(RESUME_LIMIT_CYCLES)) begin
          res_cnt_reg[g] <= res_cnt_reg[g] + 1'b1;
        end
      end
      // Level stays up until the flag is set again, by software or by an output request
      fault_reg <= fault_next;
    end
  end

  assign resume_fault_o = fault_reg;

  // ----------------------------------------------------------------
  // Skip condition
  // ----------------------------------------------------------------
  logic skip_ok;

  always_comb begin
    skip_ok = 1'b0;
    unique case (trans_subf_reg)
      SUB_SKIP_INPUT:  skip_ok = !ia_s2[trans_chan_reg];
      SUB_SKIP_OUTPUT: skip_ok = !oa_s2[trans_chan_reg];
      SUB_SKIP_FUNC:   skip_ok = !fa_s2[trans_chan_reg];
      SUB_SKIP_NORES:  skip_ok = !avail[group_of(trans_chan_reg)];
      default:         skip_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Datapath: P, D, X, adder with end-around borrow
  // ----------------------------------------------------------------
  logic [P_WIDTH-1:0] p_reg, d_reg, x_reg, memory_address_reg;
  logic               incr_flag, advance_sub_flag;
  logic               borrow_inhibit_flag, end_around_borrow;
  logic               mem_start_reg;
  logic [P_WIDTH-1:0] adder;

  // Ones-complement X - D': inhibit forces +1, inserted borrow gives -1
  always_comb begin
    adder = x_reg - ~d_reg;
    if (end_around_borrow) begin
      adder = adder - 18'h00001;
    end else if (borrow_inhibit_flag) begin
      adder = d_reg + 18'h00001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      memory_address_reg <= '0;
      mem_start_reg      <= 1'b0;
      incr_flag          <= 1'b0;
    end else begin
      mem_start_reg <= 1'b0;
      if (running && slot_reg == SLOT_T4_4) begin
        memory_address_reg <= '0;
      end
      if (running && slot_reg == SLOT_T1_1) begin
        memory_address_reg <= p_reg;
        mem_start_reg      <= 1'b1;
        incr_flag          <= !decr_reg;
      end
      if (running && slot_reg == SLOT_T2_1) begin
        incr_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p_reg               <= P_RESET;
      d_reg               <= '0;
      x_reg               <= '0;
      advance_sub_flag    <= 1'b0;
      borrow_inhibit_flag <= 1'b0;
      end_around_borrow   <= 1'b0;
    end else if (running) begin
      unique case (slot_reg)
        SLOT_T1_3: begin
          d_reg            <= '0;
          x_reg            <= decr_reg ? ALL_ONES : '0;
          advance_sub_flag <= 1'b1;
        end
        SLOT_T1_4: begin
          d_reg               <= p_reg;
          borrow_inhibit_flag <= incr_flag;
          end_around_borrow   <= decr_reg;
        end
        SLOT_T2_2: begin
          if (advance_sub_flag) p_reg <= adder;
        end
        SLOT_T2_3: begin
          advance_sub_flag    <= 1'b0;
          borrow_inhibit_flag <= 1'b0;
          end_around_borrow   <= 1'b0;
        end
        SLOT_T3_3: begin
          if (is_skip) begin
            d_reg <= '0;
            x_reg <= '0;
          end
        end
        SLOT_T3_4: begin
          if (is_skip) begin
            d_reg               <= p_reg;
            borrow_inhibit_flag <= 1'b1;
          end
        end
        SLOT_T4_2: begin
          if (is_skip && skip_ok) begin
            p_reg <= adder;
          end
        end
        SLOT_T4_3: begin
          borrow_inhibit_flag <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  assign p_o              = p_reg;
  assign memory_address_o = memory_address_reg;
  assign memory_start_o   = mem_start_reg;

endmodule

// *** rtl/io_status_pkg.sv ***
package io_status_pkg;

  // ----------------------------------------------------------------
  // Word and field widths
  // ----------------------------------------------------------------
  localparam int P_WIDTH       = 18;
  localparam int FUNC_WIDTH    = 6;
  localparam int SUBF_WIDTH    = 6;
  localparam int CHAN_SEL_W    = 4;
  localparam int NUM_CHANNELS  = 16;
  localparam int GROUP_SEL_W   = 2;
  localparam int NUM_GROUPS    = 4;
  localparam int CHAN_PER_GRP  = 4;
  localparam int SLOT_W        = 4;

  // ----------------------------------------------------------------
  // Function codes (major 50, minor octal)
  // ----------------------------------------------------------------
  localparam logic [FUNC_WIDTH-1:0] MAJOR_IO_STATUS = 6'h28;
  localparam logic [SUBF_WIDTH-1:0] SUB_SET_RESUME  = 6'h10;
  localparam logic [SUBF_WIDTH-1:0] SUB_SKIP_INPUT  = 6'h11;
  localparam logic [SUBF_WIDTH-1:0] SUB_SKIP_OUTPUT = 6'h12;
  localparam logic [SUBF_WIDTH-1:0] SUB_SKIP_FUNC   = 6'h13;
  localparam logic [SUBF_WIDTH-1:0] SUB_SKIP_NORES  = 6'h2f;

  // ----------------------------------------------------------------
  // Time slots: index = 4*(major-1) + (phase-1), one clock each
  // ----------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_T1_1 = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_T1_3 = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_T1_4 = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_T2_1 = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_T2_2 = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_T2_3 = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_T2_4 = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_T3_1 = 4'h8;
  localparam logic [SLOT_W-1:0] SLOT_T3_2 = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_T3_3 = 4'ha;
  localparam logic [SLOT_W-1:0] SLOT_T3_4 = 4'hb;
  localparam logic [SLOT_W-1:0] SLOT_T4_2 = 4'hd;
  localparam logic [SLOT_W-1:0] SLOT_T4_3 = 4'he;
  localparam logic [SLOT_W-1:0] SLOT_T4_4 = 4'hf;

  // ----------------------------------------------------------------
  // Resume-fault time limit
  // ----------------------------------------------------------------
  localparam int RESUME_LIMIT_US     = 10;
  localparam int CLK_MHZ             = 100;
  localparam int RESUME_LIMIT_CYCLES = RESUME_LIMIT_US * CLK_MHZ;
  localparam int RES_CNT_W           = 11;

  // ----------------------------------------------------------------
  // Reset values and the all-ones X load for decrement
  // ----------------------------------------------------------------
  localparam logic [P_WIDTH-1:0] P_RESET      = 18'h00000;
  localparam logic [P_WIDTH-1:0] ALL_ONES     = 18'h3ffff;
  localparam logic [NUM_GROUPS-1:0] RES_RESET = 4'hf;

endpackage

// *** sim/io_far_side.sv ***
`timescale 1ns/1ns
module io_far_side
  import io_status_pkg::*;
#(
  parameter int ACK_CYCLES = 24
)
(
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  // Word handed over by the bench
  input  wire logic                    send_i,
  input  wire logic [CHAN_SEL_W-1:0]   chan_i,
  input  wire logic                    reply_en_i,
  input  wire logic [7:0]              reply_dly_i,
  // Chassis lines
  output logic [NUM_CHANNELS-1:0]      word_sent_o,
  output logic [NUM_CHANNELS-1:0]      ack_sending_o,
  output logic [NUM_CHANNELS-1:0]      output_request_o
);
  logic [7:0]            ack_cnt_reg;
  logic [7:0]            dly_reg;
  logic                  wait_reg;
  logic [CHAN_SEL_W-1:0] chan_reg;

  // ----------------------------------------------------------------
  // Acknowledge and word timing
  // ----------------------------------------------------------------
  // Long enough that a whole status sequence can see it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_cnt_reg <= 8'h00;
    end else if (send_i) begin
      ack_cnt_reg <= 8'(ACK_CYCLES);
    end else if (ack_cnt_reg != 8'h00) begin
      ack_cnt_reg <= ack_cnt_reg - 8'h01;
    end
  end

  assign ack_sending_o = (ack_cnt_reg != 8'h00) ? 16'h1 << chan_reg : 16'h0;

  always_ff @(posedge sys_clk_i) begin
    word_sent_o <= '0;
    if (send_i) begin
      chan_reg <= chan_i;
      word_sent_o[chan_i] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receiving computer: answers after a delay, or never
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    output_request_o <= '0;
    if (sys_rst_i || send_i) begin
      wait_reg <= send_i & reply_en_i;
      dly_reg <= reply_dly_i;
    end else if (wait_reg && dly_reg == 8'h00) begin
      wait_reg <= 1'b0;
      output_request_o[chan_reg] <= 1'b1;
    end else if (wait_reg) begin
      dly_reg <= dly_reg - 8'h01;
    end
  end
endmodule

// *** sim/io_status_assertions.sv ***
`timescale 1ns/1ns
module io_status_checker
  import io_status_pkg::*;
(
  // Watched ports
  input wire logic                    sys_clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    seq_start_i,
  input wire logic                    decrement_p_i,
  input wire logic [NUM_CHANNELS-1:0] ack_sending_i,
  input wire logic [P_WIDTH-1:0]      p_o,
  input wire logic [P_WIDTH-1:0]      memory_address_o,
  input wire logic                    memory_start_o,
  input wire logic                    seq_busy_o,
  input wire logic [NUM_GROUPS-1:0]   output_available_o,
  input wire logic [NUM_GROUPS-1:0]   resume_o,
  input wire logic                    resume_fault_o
);
  logic [NUM_GROUPS-1:0] ack_grp;
  logic [P_WIDTH-1:0]    p_start_reg;
  logic                  decr_reg;
  logic [RES_CNT_W-1:0]  clr_cnt_reg;
  wire logic             take = seq_start_i & ~seq_busy_o;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      ack_grp[g] = |ack_sending_i[g*CHAN_PER_GRP +: CHAN_PER_GRP];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p_start_reg <= '0;
      decr_reg <= 1'b0;
    end else if (take) begin
      p_start_reg <= p_o;
      decr_reg <= decrement_p_i;
    end
  end

  // Counts from the moment any group loses its resume flag
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || &resume_o) begin
      clr_cnt_reg <= '0;
    end else if (clr_cnt_reg != '1) begin
      clr_cnt_reg <= clr_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_mem_start;
    take |-> ##2 memory_start_o;
  endproperty
  a_mem_start: assert property (p_mem_start)
    else $error("memory start missing after sequence start");

  property p_addr_p;
    memory_start_o |-> memory_address_o == p_o;
  endproperty
  a_addr_p: assert property (p_addr_p)
    else $error("address differs from P at memory start");

  property p_addr_clear;
    $fell(seq_busy_o) |-> memory_address_o == '0;
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("address not cleared at end of sequence");

  property p_busy_len;
    take |=> seq_busy_o [*8] ##1 seq_busy_o [*8] ##1 !seq_busy_o;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("sequence length wrong");

  property p_step;
    $fell(seq_busy_o) && !decr_reg |->
      p_o == p_start_reg + 18'h1 || p_o == p_start_reg + 18'h2;
  endproperty
  a_step: assert property (p_step)
    else $error("P not advanced by one or two");

  property p_decr;
    $fell(seq_busy_o) && decr_reg |-> p_o == p_start_reg - 18'h1;
  endproperty
  a_decr: assert property (p_decr)
    else $error("P not stepped back by one");

  property p_avail_res;
    (output_available_o & ~resume_o) == 4'h0;
  endproperty
  a_avail_res: assert property (p_avail_res)
    else $error("output available without resume");

  property p_ack_block;
    (ack_grp & $past(ack_grp, 1) & $past(ack_grp, 2) & $past(ack_grp, 3)
      & output_available_o) == 4'h0;
  endproperty
  a_ack_block: assert property (p_ack_block)
    else $error("output available during acknowledge");

  property p_fault_time;
    $rose(resume_fault_o) |-> int'(clr_cnt_reg) >= RESUME_LIMIT_CYCLES - 8;
  endproperty
  a_fault_time: assert property (p_fault_time)
    else $error("resume fault raised too early");
endmodule

bind io_status_skip_resume_exec io_status_checker u_chk (
  .sys_clk_i          (sys_clk_i),
  .sys_rst_i          (sys_rst_i),
  .seq_start_i        (seq_start_i),
  .decrement_p_i      (decrement_p_i),
  .ack_sending_i      (ack_sending_i),
  .p_o                (p_o),
  .memory_address_o   (memory_address_o),
  .memory_start_o     (memory_start_o),
  .seq_busy_o         (seq_busy_o),
  .output_available_o (output_available_o),
  .resume_o           (resume_o),
  .resume_fault_o     (resume_fault_o)
);

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import io_status_pkg::*;

  typedef struct packed {
    logic [SUBF_WIDTH-1:0]   subf;
    logic [CHAN_SEL_W-1:0]   chan;
    logic [NUM_CHANNELS-1:0] ia;
    logic [NUM_CHANNELS-1:0] oa;
    logic [NUM_CHANNELS-1:0] fa;
    logic                    skip;
  } row_t;

  localparam row_t ROWS [9] = '{
    '{SUB_SKIP_INPUT, 4'h3, 16'h0000, 16'hffff, 16'hffff, 1'b1},
    '{SUB_SKIP_INPUT, 4'h3, 16'h0008, 16'h0000, 16'h0000, 1'b0},
    '{SUB_SKIP_INPUT, 4'h3, 16'hfff7, 16'h0000, 16'h0000, 1'b1},
    '{SUB_SKIP_OUTPUT, 4'h9, 16'h0000, 16'h0200, 16'h0000, 1'b0},
    '{SUB_SKIP_OUTPUT, 4'h9, 16'hffff, 16'hfdff, 16'hffff, 1'b1},
    '{SUB_SKIP_FUNC, 4'hf, 16'h0000, 16'h0000, 16'h8000, 1'b0},
    '{SUB_SKIP_FUNC, 4'hf, 16'hffff, 16'hffff, 16'h7fff, 1'b1},
    '{SUB_SKIP_NORES, 4'h5, 16'h0000, 16'h0000, 16'h0000, 1'b0},
    '{SUB_SET_RESUME, 4'hc, 16'h0000, 16'h0000, 16'h0000, 1'b0}
  };

  logic                    sys_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    seq_start = 1'b0;
  logic                    decr = 1'b0;
  logic [FUNC_WIDTH-1:0]   func = '0;
  logic [SUBF_WIDTH-1:0]   subf = '0;
  logic [CHAN_SEL_W-1:0]   chan = '0;
  logic [NUM_CHANNELS-1:0] in_act = '0;
  logic [NUM_CHANNELS-1:0] out_act = '0;
  logic [NUM_CHANNELS-1:0] fn_act = '0;
  logic                    ic_mode = 1'b0;
  logic                    send = 1'b0;
  logic [CHAN_SEL_W-1:0]   send_chan = '0;
  logic                    reply_en = 1'b0;
  logic [7:0]              reply_dly = 8'h00;
  logic [NUM_CHANNELS-1:0] ack;
  logic [NUM_CHANNELS-1:0] sent;
  logic [NUM_CHANNELS-1:0] req;
  logic [P_WIDTH-1:0]      p;
  logic [P_WIDTH-1:0]      exp_p = P_RESET;
  logic                    busy;
  logic [NUM_GROUPS-1:0]   avail;
  logic [NUM_GROUPS-1:0]   resume;
  logic                    fault;
  int                      mismatches = 0;
  int                      n_checks = 0;

  always #5 sys_clk = ~sys_clk;

  io_status_skip_resume_exec i_dut (
    .sys_clk_i                (sys_clk),
    .sys_rst_i                (sys_rst),
    .seq_start_i              (seq_start),
    .decrement_p_i            (decr),
    .instr_func_i             (func),
    .instr_subf_i             (subf),
    .instr_chan_i             (chan),
    .input_buffer_active_i    (in_act),
    .output_buffer_active_i   (out_act),
    .function_buffer_active_i (fn_act),
    .ack_sending_i            (ack),
    .word_sent_i              (sent),
    .output_request_i         (req),
    .intercomputer_mode_i     (ic_mode),
    .p_o                      (p),
    .memory_address_o         (),
    .memory_start_o           (),
    .seq_busy_o               (busy),
    .output_available_o       (avail),
    .resume_o                 (resume),
    .resume_fault_o           (fault)
  );

  io_far_side i_far (
    .sys_clk_i        (sys_clk),
    .sys_rst_i        (sys_rst),
    .send_i           (send),
    .chan_i           (send_chan),
    .reply_en_i       (reply_en),
    .reply_dly_i      (reply_dly),
    .word_sent_o      (sent),
    .ack_sending_o    (ack),
    .output_request_o (req)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bad(input string msg);
    mismatches++;
    $display("BAD t=%0t %s", $time, msg);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_p(input logic [P_WIDTH-1:0] e);
    n_checks++;
    if (p !== e) bad($sformatf("P %h expected %h", p, e));
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] e);
    n_checks++;
    if (got !== e) bad($sformatf("flags %h expected %h", got, e));
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic run(input logic [SUBF_WIDTH-1:0] sf,
                     input logic [CHAN_SEL_W-1:0] ch, input logic dec);
    int n;
    @(negedge sys_clk);
    seq_start = 1'b1;
    decr = dec;
    func = dec ? 6'h00 : MAJOR_IO_STATUS;
    subf = sf;
    chan = ch;
    @(negedge sys_clk);
    seq_start = 1'b0;
    n = 0;
    while (busy !== 1'b0) begin
      if (n == 30) begin
        bad("sequence hangs");
        test_done();
      end
      n++;
      @(negedge sys_clk);
    end
  endtask

  task automatic send_word(input logic [3:0] ch, input logic en);
    @(negedge sys_clk);
    send = 1'b1;
    send_chan = ch;
    reply_en = en;
    reply_dly = 8'h06;
    @(negedge sys_clk);
    send = 1'b0;
  endtask

  // Index 4 watches the fault flag, 0 to 3 a resume flag
  task automatic wait_bit(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (((idx == 4) ? fault : resume[idx]) !== v) begin
      if (n == lim) begin
        bad("wait ran out");
        test_done();
      end
      n++;
      @(negedge sys_clk);
    end
    n_checks++;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(16);
    sys_rst = 1'b0;
    chk_p(P_RESET);
    chk_flags(avail, RES_RESET);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      in_act = ROWS[i].ia;
      out_act = ROWS[i].oa;
      fn_act = ROWS[i].fa;
      run(ROWS[i].subf, ROWS[i].chan, 1'b0);
      exp_p = exp_p + (ROWS[i].skip ? 18'h2 : 18'h1);
      chk_p(exp_p);
    end
    $display("test table done");
    send_word(4'h6, 1'b0);
    step(2);
    chk_flags(avail, 4'hd);
    run(SUB_SKIP_NORES, 4'h7, 1'b0);
    exp_p = exp_p + 18'h2;
    chk_p(exp_p);
    step(30);
    chk_flags(avail, 4'hf);
    $display("test acknowledge done");
    ic_mode = 1'b1;
    step(3);
    send_word(4'ha, 1'b1);
    wait_bit(2, 1'b0, 10);
    wait_bit(2, 1'b1, 40);
    send_word(4'hd, 1'b0);
    wait_bit(3, 1'b0, 10);
    run(SUB_SKIP_NORES, 4'he, 1'b0);
    exp_p = exp_p + 18'h2;
    chk_p(exp_p);
    wait_bit(4, 1'b1, 1100);
    run(SUB_SET_RESUME, 4'hc, 1'b0);
    exp_p = exp_p + 18'h1;
    chk_p(exp_p);
    chk_flags(resume, 4'hf);
    wait_bit(4, 1'b0, 5);
    run(SUB_SKIP_NORES, 4'hd, 1'b0);
    exp_p = exp_p + 18'h1;
    chk_p(exp_p);
    $display("test intercomputer done");
    run(6'h00, 4'h0, 1'b1);
    exp_p = exp_p - 18'h1;
    chk_p(exp_p);
    $display("test decrement done");
    @(negedge sys_clk);
    seq_start = 1'b1;
    @(negedge sys_clk);
    seq_start = 1'b0;
    step(6);
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    exp_p = P_RESET;
    chk_p(exp_p);
    chk_flags(resume, RES_RESET);
    in_act = '0;
    run(SUB_SKIP_INPUT, 4'h0, 1'b0);
    chk_p(exp_p + 18'h2);
    $display("test mid reset done");
    test_done();
  end
endmodule
